/* File: core/psp_pkg.sv */
// Purpose: shared constants and types of the parallel host port status block
// Assumes: byte addresses on the register bus are four times the register index
// Notes: indices below 0x100, so a 10-bit byte address covers the whole map
package psp_pkg;

   localparam int PSP_AW = 10;
   localparam int PSP_IW = 8;

   // register indices; byte address = 4 * index
   localparam logic [PSP_IW-1:0] PSP_IDX_DATA = 8'h08;
   localparam logic [PSP_IW-1:0] PSP_IDX_STRB = 8'h09;
   localparam logic [PSP_IW-1:0] PSP_IDX_DDIR = 8'h88;
   localparam logic [PSP_IW-1:0] PSP_IDX_CTL = 8'h89;
   localparam logic [PSP_IW-1:0] PSP_IDX_IFLG = 8'h0c;
   localparam logic [PSP_IW-1:0] PSP_IDX_IMSK = 8'h8c;

   // field positions in the status and direction register, and the irq bit of the interrupt flag and mask registers
   localparam int PSP_BIT_IBF = 7;
   localparam int PSP_BIT_OBF = 6;
   localparam int PSP_BIT_OVF = 5;
   localparam int PSP_BIT_MODE = 4;
   localparam int PSP_BIT_IRQ = 7;

   // strobe port pin positions
   localparam int PSP_PIN_CS = 2;
   localparam int PSP_PIN_WR = 1;
   localparam int PSP_PIN_RD = 0;

   // reset values
   localparam logic [7:0] PSP_CTL_RST = 8'h07;
   localparam logic [7:0] PSP_DDIR_RST = 8'hff;
   localparam logic [7:0] PSP_BYTE_RST = 8'h00;
   localparam logic [2:0] PSP_STRB_RST = 3'h0;

   typedef struct packed {
      logic input_full_flag;
      logic output_full_flag;
      logic input_overrun_flag;
      logic host_port_select;
      logic unused_zero;
      logic [2:0] strobe_dir;
   } psp_ctl_t;

   typedef struct packed {
      logic [2:0] strobe;
      logic [7:0] data;
   } psp_pins_t;

   typedef enum logic [1:0] {
      PSP_BUS_IDLE = 2'b01,
      PSP_BUS_ACK = 2'b10
   } psp_bus_t;

endpackage : psp_pkg

/* File: core/psp_sync.sv */
// Purpose: two-stage synchroniser for the port pins
// Assumes: pins are asynchronous to clk_sys
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module psp_sync #(
   parameter int W = 11
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         logic stage2;
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               meta <= 1'b1;
               stage2 <= 1'b1;
            end else if (ce) begin
               meta <= d[i];
               stage2 <= meta;
            end
         end
         // one process per bit writes its own stage; the output is just a view of it
         assign q[i] = stage2;
      end
   endgenerate

endmodule : psp_sync

`default_nettype wire

/* File: core/psp_status.sv */
// Purpose: parallel host port data buffers, status flags and strobe port control
// Assumes: avalon-mm slave with waitrequest, 32-bit data, byte addressing
// Notes: host strobes are active low and are synchronised before use
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R01) The input-full flag, bit 7, is set while a host-written byte is unread by the CPU.
// (R02) The output-full flag, bit 6, is one while a CPU byte waits and clears once the host reads it.
// (R03) A host write while the input byte is unread sets the overrun flag, bit 5, until software clears it.
// (R04) Mode select bit 4 makes the data port the host port when one and plain I/O when zero.
// (R05) Bits 2 to 0 set the strobe pin directions, one meaning input and zero output.
// (R06) The host drives chip select on strobe pin 2, write on pin 1 and read on pin 0.
// (R07) Bit 3 of the control register is unimplemented and reads zero.
// (R08) Full flags are read-only and reset to zero, overrun and mode reset to zero, directions to one.
// (R09) Without the host port, software keeps its interrupt flag and enable cleared.
// (R10) On reduced variants the data port, strobe port and both direction registers read zero.
// (R11) A host write in host port mode latches the data, sets input-full and raises the irq flag.
// (R12) A CPU data read clears input-full; a host read drives the output buffer and clears output-full.
module psp_status
   import psp_pkg::*;
#(
   parameter bit HAS_PORT = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [PSP_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic [7:0] data_pin_in,
   output logic [7:0] data_pin_out,
   output logic [7:0] data_pin_oe,
   input wire logic [2:0] strobe_pin_in,
   output logic [2:0] strobe_pin_out,
   output logic [2:0] strobe_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and host strobe decode

   psp_pins_t pins_raw;
   psp_pins_t pins_s;
   logic wr_act_q;
   logic rd_act_q;

   assign pins_raw = '{strobe: strobe_pin_in, data: data_pin_in};

   psp_sync #(.W(11)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .d(pins_raw),
      .q(pins_s)
   );

   psp_ctl_t ctl;
   wire mode = HAS_PORT & ctl.host_port_select;
   // strobes are active low; chip select gates both
   wire cs_act = ~pins_s.strobe[PSP_PIN_CS]; // [R06]
   wire wr_act = cs_act & ~pins_s.strobe[PSP_PIN_WR]; // [R06]
   wire rd_act = cs_act & ~pins_s.strobe[PSP_PIN_RD]; // [R06]
   // data is taken at the start of the write strobe; host holds it with the strobe
   wire host_wr_ev = mode & wr_act & ~wr_act_q; // [R11]
   wire host_rd_end = mode & rd_act_q & ~rd_act; // [R12]

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
      end else if (ce) begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, read data registered in that cycle

   psp_bus_t bus_st;
   psp_bus_t next_bus_st;
   wire req = avs_read | avs_write;
   wire done = (bus_st == PSP_BUS_ACK);
   wire [PSP_IW-1:0] idx = avs_address[PSP_AW-1:2];
   wire hit_data = (idx == PSP_IDX_DATA);
   wire hit_strb = (idx == PSP_IDX_STRB);
   wire hit_ddir = (idx == PSP_IDX_DDIR);
   wire hit_ctl = (idx == PSP_IDX_CTL);
   wire hit_iflg = (idx == PSP_IDX_IFLG);
   wire hit_imsk = (idx == PSP_IDX_IMSK);
   // only byte lane 0 carries data; other lanes are ignored
   wire wr_acc = avs_write & done & avs_byteenable[0];
   wire rd_acc = avs_read & done;
   wire [7:0] wd = avs_writedata[7:0];

   // no answer while frozen, so a held request is never accepted without effect
   assign avs_waitrequest = req & ~(done & ce);

   always_comb begin
      case (bus_st)
         PSP_BUS_IDLE: next_bus_st = req ? PSP_BUS_ACK : PSP_BUS_IDLE;
         PSP_BUS_ACK: next_bus_st = PSP_BUS_IDLE;
         default: next_bus_st = PSP_BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_st <= PSP_BUS_IDLE;
      end else if (ce) begin
         bus_st <= next_bus_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // buffers, flags and direction registers

   logic [7:0] in_buf;
   logic [7:0] out_buf;
   logic [7:0] ddir;
   logic [2:0] strb_latch;
   logic irq_flag;
   logic irq_mask;

   wire cpu_data_wr = HAS_PORT & wr_acc & hit_data;
   wire cpu_data_rd = rd_acc & hit_data & mode;
   wire ctl_wr = HAS_PORT & wr_acc & hit_ctl;
   // hardware set wins over any clear in the same cycle
   wire next_ibf = host_wr_ev | (ctl.input_full_flag & ~cpu_data_rd); // [R01] [R12]
   wire next_obf = (cpu_data_wr & mode) | (ctl.output_full_flag & ~host_rd_end); // [R02]
   wire ovf_sw = ctl_wr ? wd[PSP_BIT_OVF] : ctl.input_overrun_flag;
   wire next_ovf = (host_wr_ev & ctl.input_full_flag) | ovf_sw; // [R03]
   wire next_mode = ctl_wr ? wd[PSP_BIT_MODE] : ctl.host_port_select; // [R04]
   wire [2:0] next_sdir = ctl_wr ? wd[2:0] : ctl.strobe_dir; // [R05]
   wire irq_ev = host_wr_ev | host_rd_end; // [R11]
   wire irq_clr = wr_acc & hit_iflg & wd[PSP_BIT_IRQ];
   wire next_irq_flag = irq_ev | (irq_flag & ~irq_clr);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctl <= PSP_CTL_RST; // [R08]
         in_buf <= PSP_BYTE_RST;
         out_buf <= PSP_BYTE_RST;
         ddir <= PSP_DDIR_RST;
         strb_latch <= PSP_STRB_RST;
         irq_flag <= 1'b0;
         irq_mask <= 1'b0;
      end else if (ce) begin
         ctl <= '{next_ibf, next_obf, next_ovf, next_mode, 1'b0, next_sdir}; // [R07] [R08]
         if (host_wr_ev) begin
            in_buf <= pins_s.data; // [R11]
         end
         if (cpu_data_wr) begin
            out_buf <= wd;
         end
         if (HAS_PORT & wr_acc & hit_ddir) begin
            ddir <= wd;
         end
         if (HAS_PORT & wr_acc & hit_strb) begin
            strb_latch <= wd[2:0];
         end
         irq_flag <= next_irq_flag;
         if (wr_acc & hit_imsk) begin
            irq_mask <= wd[PSP_BIT_IRQ];
         end
      end
   end

   assign irq = irq_flag & irq_mask;

   ////////////////////////////////////////////////////////////////////////////////
   // pin drive

   // in host port mode the data pins drive only while the host reads
   wire [7:0] data_oe_sel = mode ? {8{rd_act}} : ~ddir; // [R04] [R12]
   assign data_pin_oe = HAS_PORT ? data_oe_sel : 8'h00; // [R10]
   assign data_pin_out = out_buf;
   assign strobe_pin_oe = HAS_PORT ? ~ctl.strobe_dir : 3'h0; // [R05]
   assign strobe_pin_out = strb_latch;

   ////////////////////////////////////////////////////////////////////////////////
   // read mux

   wire [7:0] rd_data = mode ? in_buf : pins_s.data; // [R04]
   wire [7:0] rd_strb = {5'h00, pins_s.strobe};
   wire [7:0] rd_port = hit_data ? rd_data : hit_strb ? rd_strb : hit_ddir ? ddir : ctl;
   wire port_hit = hit_data | hit_strb | hit_ddir | hit_ctl;
   // reduced variants answer every port register with zero
   wire [7:0] rd_p = (HAS_PORT & port_hit) ? rd_port : 8'h00; // [R10] [R07]
   wire [7:0] rd_i = hit_iflg ? {irq_flag, 7'h00} : hit_imsk ? {irq_mask, 7'h00} : 8'h00;
   wire [7:0] rd_byte = rd_p | rd_i;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (ce && avs_read && !done) begin
         avs_readdata <= {24'h000000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_ibf_set: assert property (ce && host_wr_ev |=> ctl.input_full_flag) // [R01]
      else $error("input full not set by host write");
   chk_ibf_clear: assert property (ce && cpu_data_rd && !host_wr_ev |=> !ctl.input_full_flag) // [R12]
      else $error("input full not cleared by cpu read");
   chk_obf_hold: assert property (ce && cpu_data_wr && mode ##1 !host_rd_end [*3] // [R02]
      |-> ctl.output_full_flag)
      else $error("output full dropped without host read");
   chk_obf_clear: assert property (ce && host_rd_end && !cpu_data_wr |=> !ctl.output_full_flag) // [R02]
      else $error("output full not cleared by host read");
   chk_ovf_set: assert property (ce && host_wr_ev && ctl.input_full_flag // [R03]
      |=> ctl.input_overrun_flag)
      else $error("overrun not flagged");
   chk_ovf_sticky: assert property (ctl.input_overrun_flag && !ctl_wr // [R03]
      |=> ctl.input_overrun_flag)
      else $error("overrun cleared without software");
   chk_ctl_zero_bits: assert property (rd_acc && hit_ctl |-> avs_readdata[31:8] == 24'h0 // [R07]
      && !avs_readdata[3])
      else $error("unimplemented control bits read nonzero");
   chk_gpio_dir: assert property (HAS_PORT && !mode |-> data_pin_oe == ~ddir) // [R04]
      else $error("gpio direction not honoured");
   chk_strobe_dir: assert property (HAS_PORT |-> strobe_pin_oe == ~ctl.strobe_dir) // [R05]
      else $error("strobe direction not honoured");
   chk_reset_vals: assert property ($past(rst) |-> ctl == PSP_CTL_RST && ddir == PSP_DDIR_RST) // [R08]
      else $error("wrong reset values");
   chk_reduced_zero: assert property (!HAS_PORT && rd_acc && port_hit // [R10]
      |-> avs_readdata == 32'h0)
      else $error("reduced variant port register nonzero");
   chk_host_irq: assert property (ce && host_wr_ev && irq_mask |=> irq ##1 irq) // [R11]
      else $error("host write raised no interrupt");
   chk_bus_answer: assert property (ce && req && !done |=> !avs_waitrequest)
      else $error("bus answer late");
   chk_obf_set: assert property (ce && cpu_data_wr && mode // [R02]
      |=> ctl.output_full_flag)
      else $error("output full not set by cpu write");
   chk_ibf_hold: assert property (ctl.input_full_flag && !cpu_data_rd // [R01]
      |=> ctl.input_full_flag)
      else $error("input full dropped without cpu read");
   chk_ovf_sw_clear: assert property (ce && ctl_wr && !wd[PSP_BIT_OVF] // [R03]
      && !(host_wr_ev && ctl.input_full_flag) |=> !ctl.input_overrun_flag)
      else $error("overrun not cleared by software");
   chk_mode_write: assert property (ce && ctl_wr // [R04]
      |=> ctl.host_port_select == $past(wd[PSP_BIT_MODE]))
      else $error("mode select not written");
   chk_dir_write: assert property (ce && ctl_wr // [R05]
      |=> ctl.strobe_dir == $past(wd[2:0]))
      else $error("strobe directions not written");
   chk_ro_flags: assert property (ce && ctl_wr && !host_wr_ev && !host_rd_end // [R08]
      |=> ctl.input_full_flag == $past(ctl.input_full_flag)
      && ctl.output_full_flag == $past(ctl.output_full_flag))
      else $error("read-only flag changed by a write");
   chk_reduced_pins: assert property (!HAS_PORT // [R10]
      |-> data_pin_oe == 8'h00 && strobe_pin_oe == 3'h0)
      else $error("reduced variant drives a pin");
   chk_data_latch: assert property (ce && host_wr_ev // [R11]
      |=> in_buf == $past(pins_s.data))
      else $error("host byte not latched");
   chk_irq_flag_set: assert property (ce && host_wr_ev // [R11]
      |=> irq_flag)
      else $error("host write left irq flag clear");
   chk_host_drive: assert property (mode && rd_act // [R12]
      |-> data_pin_oe == 8'hff)
      else $error("data pins not driven during host read");
   chk_host_release: assert property (mode && !rd_act // [R12]
      |-> data_pin_oe == 8'h00)
      else $error("data pins driven outside host read");
   chk_irq_clear: assert property (ce && irq_clr && !irq_ev
      |=> !irq_flag)
      else $error("irq flag not cleared by write one");
   chk_ce_freeze: assert property (!ce
      |=> $stable(ctl) && $stable(in_buf) && $stable(out_buf))
      else $error("state changed while clock enable low");
   chk_ce_wait: assert property (!ce && req
      |-> avs_waitrequest)
      else $error("bus answered while clock enable low");
   chk_strobe_latch: assert property (ce && HAS_PORT && wr_acc && hit_strb
      |=> strobe_pin_out == $past(wd[2:0]))
      else $error("strobe port latch not written");
   chk_gpio_latch: assert property (ce && cpu_data_wr // [R04]
      |=> data_pin_out == $past(wd))
      else $error("data port latch not written");
   chk_readdata_upper: assert property (rd_acc
      |-> avs_readdata[31:8] == 24'h000000)
      else $error("upper read data lanes nonzero");

   cov_host_write: cover property (host_wr_ev ##[1:50] cpu_data_rd);
   cov_host_read: cover property (cpu_data_wr ##[1:50] host_rd_end);
   cov_overrun: cover property (host_wr_ev && ctl.input_full_flag);
   cov_irq_clear: cover property (irq ##1 !irq);
   cov_ce_freeze: cover property (!ce ##1 ce);

endmodule : psp_status

`default_nettype wire

/* File: tb/psp_host_model.sv */
// Purpose: behavioural external host for the parallel host port
// Assumes: strobes active low, one access at a time
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module psp_host_model (
   input wire logic clk_sys,
   input wire logic [7:0] dev_data,
   output logic [7:0] host_data,
   output logic [2:0] host_strobe
);
   initial begin
      host_data = 8'h00;
      host_strobe = 3'h7;
   end
   // n is the strobe low and high time in cycles, 3 at the least
   task automatic host_wr(input logic [7:0] d, input int n);
      @(posedge clk_sys);
      host_data <= d;
      @(posedge clk_sys);
      host_strobe <= 3'b001;
      repeat (n) @(posedge clk_sys);
      host_strobe <= 3'h7;
      repeat (n) @(posedge clk_sys);
      host_data <= ~d;
   endtask : host_wr
   task automatic host_rd(output logic [7:0] d, input int n);
      @(posedge clk_sys);
      host_strobe <= 3'b010;
      repeat (n) @(posedge clk_sys);
      d = dev_data;
      host_strobe <= 3'h7;
      repeat (n) @(posedge clk_sys);
   endtask : host_rd
endmodule : psp_host_model
`default_nettype wire

/* File: tb/psp_status_tb_top.sv */
// Purpose: self-checking bench of the host port status block
// Assumes: one wait cycle per bus access, host model on the pins
// Notes: byteenable tied on; a reduced variant shares the read side of the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   $display("unexpected %s exp %h got %h", nm, e, g); num_errors++; end end
module psp_status_tb_top;
   import psp_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, ce = 1'b1;
   logic [31:0] red_rdata;
   logic [PSP_AW-1:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata;
   logic avs_waitrequest, irq;
   logic [7:0] data_pin_in, data_pin_out, data_pin_oe, host_data, rd_q;
   logic [2:0] strobe_pin_in, strobe_pin_out, strobe_pin_oe, host_strobe;
   int num_errors = 0, cmp_count = 0, cycles = 0;
   // wire levels resolved from the block's enables alone; the host drives wherever the block does not
   assign data_pin_in = (data_pin_oe & data_pin_out) | (~data_pin_oe & host_data);
   assign strobe_pin_in = (strobe_pin_oe & strobe_pin_out) | (~strobe_pin_oe & host_strobe);
   psp_status dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
      .data_pin_oe(data_pin_oe), .strobe_pin_in(strobe_pin_in),
      .strobe_pin_out(strobe_pin_out), .strobe_pin_oe(strobe_pin_oe));
   // reduced variant is never written, so its irq flag and enable stay clear
   psp_status #(.HAS_PORT(1'b0)) dut_red_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(1'b0),
      .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(red_rdata),
      .avs_waitrequest(), .irq(), .data_pin_in(host_data), .data_pin_out(),
      .data_pin_oe(), .strobe_pin_in(host_strobe), .strobe_pin_out(),
      .strobe_pin_oe());
   psp_host_model host_u (.clk_sys(clk_sys), .dev_data(data_pin_in),
      .host_data(host_data), .host_strobe(host_strobe));
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      // whole run is a couple of hundred cycles
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   // waitrequest is sampled at the rising edge that accepts the request
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) `CHK("waitrequest", 1'b0, avs_waitrequest)
      rd_q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // callers look at outputs only once the accepting edge has settled
      @(negedge clk_sys);
   endtask : bus
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK("readdata", e, rd_q)
   endtask : rd_chk
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk(10'h224, 8'h07);
      `CHK("reduced_ctl", 32'h0, red_rdata)
      `CHK("strobe_oe", 3'h0, strobe_pin_oe)
   endtask : t_reset
   task automatic t_ctl;
      // latch high first, so strobe pins turned to outputs show no host access
      bus(1'b1, 10'h024, 8'h07);
      bus(1'b1, 10'h224, 8'h0a);
      rd_chk(10'h224, 8'h02);
      `CHK("strobe_oe", 3'b101, strobe_pin_oe)
      `CHK("strobe_out", 3'h7, strobe_pin_out)
      rd_chk(10'h024, 8'h07);
      bus(1'b1, 10'h224, 8'hff);
      rd_chk(10'h224, 8'h37);
      bus(1'b1, 10'h224, 8'h17);
      rd_chk(10'h224, 8'h17);
   endtask : t_ctl
   task automatic t_hwrite;
      bus(1'b1, 10'h230, 8'h80);
      host_u.host_wr(8'h5a, 4);
      rd_chk(10'h224, 8'h97);
      `CHK("irq", 1'b1, irq)
      host_u.host_wr(8'ha5, 8);
      rd_chk(10'h224, 8'hb7);
      rd_chk(10'h020, 8'ha5);
      rd_chk(10'h224, 8'h37);
      bus(1'b1, 10'h224, 8'h17);
      rd_chk(10'h224, 8'h17);
      bus(1'b1, 10'h030, 8'h80);
      `CHK("irq", 1'b0, irq)
   endtask : t_hwrite
   task automatic t_hread;
      logic [7:0] q;
      bus(1'b1, 10'h020, 8'h3c);
      rd_chk(10'h224, 8'h57);
      host_u.host_rd(q, 4);
      `CHK("host_data", 8'h3c, q)
      rd_chk(10'h224, 8'h17);
      // a host write made while the block is frozen must leave no trace
      @(posedge clk_sys);
      ce <= 1'b0;
      host_u.host_wr(8'h42, 4);
      ce <= 1'b1;
      rd_chk(10'h224, 8'h17);
   endtask : t_hread
   task automatic t_gpio;
      bus(1'b1, 10'h224, 8'h07);
      host_u.host_wr(8'h11, 4);
      rd_chk(10'h224, 8'h07);
      bus(1'b1, 10'h220, 8'h00);
      bus(1'b1, 10'h020, 8'h66);
      `CHK("data_oe", 8'hff, data_pin_oe)
      `CHK("data_out", 8'h66, data_pin_out)
      // pins reach the read path through two synchroniser stages
      repeat (2) @(posedge clk_sys);
      rd_chk(10'h020, 8'h66);
      `CHK("reduced_data", 32'h0, red_rdata)
   endtask : t_gpio
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_ctl();
      t_hwrite();
      t_hread();
      t_gpio();
      end_of_test();
   end
endmodule : psp_status_tb_top
`default_nettype wire
